//--- aes_axis_params.sv
// Contract
// - Index counts only when A, B and index levels match mode bits 0-2.
// - Mode bit 3 ignores A and B, index line alone qualifies.
// - Mode bit 4 acts on every qualified index event.
// - Mode bit 5 acts once at the next qualified index event.
// - Index latches count and position; mode bit 8 also clears counter.
// - Full steps per revolution, 16 bits, default 200.
// - With zero standby current, coils follow the idle treatment setting.
// - Read-only load measurement, 0 to 1023.
// - Extended flags: stall 1, deviation 2; clear on read or command.
// - Driver flag bit 0 stall, bit 1 overtemperature shutdown.
// - Driver flag bit 2 while overtemperature pre-warning is exceeded.
// - Driver flag bits 3 and 4 show shorts to ground on A, B.
// - Driver flag bits 5 and 6 show open load on A, B.
// - Driver flag bit 7 when no step for 2^20 clocks.
// - Motion commands fan out to axes sharing a nonzero group.
// - Wait idle delay in 10 ms units before standby current; default 200.
// - Shaft invert setting 1 reverses rotation for all motion.
// - Unit mode 0 raw units, 1 pulse units; default 1.
// - Encoder counts per revolution, 16 bits, read and write.
// - Index latch captures position and encoder count, signed 32 bits.
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module aes_axis_params #(
	parameter int STANDSTILL_CYCLES = aes_pkg::STANDSTILL_CYCLES,
	parameter int IDLE_UNIT_CYCLES  = aes_pkg::IDLE_UNIT_CYCLES
) (
	// Clock and reset
	input  wire logic                       clk,
	input  wire logic                       reset,
	// AXI4-Lite slave
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [aes_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	output logic [1:0]                      s_axi_bresp,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	input  wire logic [aes_pkg::ADDR_W-1:0] s_axi_araddr,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	// Encoder pins
	input  wire logic                       enc_a,
	input  wire logic                       enc_b,
	input  wire logic                       enc_n,
	// Driver stage status pins
	input  wire logic                       drv_stall,
	input  wire logic                       drv_overtemp,
	input  wire logic                       drv_overtemp_warn,
	input  wire logic                       drv_short_a,
	input  wire logic                       drv_short_b,
	input  wire logic                       drv_open_a,
	input  wire logic                       drv_open_b,
	input  wire logic [aes_pkg::LOAD_W-1:0] drv_load,
	// Motion controller side
	input  wire logic signed [31:0]         actual_position,
	input  wire logic                       step_pulse,
	input  wire logic                       standby_current_zero,
	// Commands
	input  wire logic                       local_cmd_valid,
	input  wire aes_pkg::aes_cmd_e          local_cmd,
	input  wire logic                       peer_cmd_valid,
	input  wire aes_pkg::aes_cmd_e          peer_cmd,
	input  wire logic [7:0]                 peer_group,
	output logic                            motion_cmd_valid,
	output aes_pkg::aes_cmd_e               motion_cmd,
	output logic                            bcast_cmd_valid,
	output aes_pkg::aes_cmd_e               bcast_cmd,
	output logic [7:0]                      bcast_group,
	// Settings and supervision out
	output logic                            deviation_stop,
	output logic [1:0]                      coil_mode,
	output logic                            idle_current,
	output logic                            shaft_invert,
	output logic                            pps_units,
	output logic [15:0]                     steps_per_rev,
	output logic [15:0]                     enc_counts_per_rev
);
	import aes_pkg::*;

	localparam int SC_W = $clog2(STANDSTILL_CYCLES + 1);
	localparam int TK_W = $clog2(IDLE_UNIT_CYCLES + 1);

	// ==========================================
	// State
	typedef struct packed {
		logic [SYN_W-1:0] s1;
		logic [SYN_W-1:0] s2;
		logic [SYN_W-1:0] s3;
		logic [8:0]       enc_mode;
		logic [15:0]      steps;
		logic [1:0]       coil_set;
		logic [1:0]       ext;
		logic [31:0]      enc_cnt;
		logic [15:0]      enc_res;
		logic [15:0]      dev_lim;
		logic [7:0]       group;
		logic [8:0]       idle_dly;
		logic             shaft;
		logic             units;
		logic [31:0]      lat_act;
		logic [31:0]      lat_enc;
		logic             once_armed;
		logic             idx_q;
		logic [SC_W-1:0]  still_cnt;
		logic             still;
		logic [TK_W-1:0]  tick;
		logic [8:0]       idle_units;
		logic             idle;
		logic [1:0]       coil;
		logic             over_q;
		logic             dev_stop;
		logic             mcmd_v;
		aes_cmd_e         mcmd;
		logic             bc_v;
		aes_cmd_e         bc;
		logic [7:0]       bc_grp;
		logic             aw_got;
		logic [7:0]       aw_idx;
		logic             w_got;
		logic [31:0]      w_data;
		logic [3:0]       w_strb;
		logic             aw_rdy;
		logic             w_rdy;
		logic             bvalid;
		logic [1:0]       bresp;
		logic             ar_rdy;
		logic             rvalid;
		logic [31:0]      rdata;
		logic [1:0]       rresp;
	} aes_state_s;

	localparam aes_state_s ST_RST = '{
		steps:    STEPS_RST,
		idle_dly: IDLE_DLY_RST,
		units:    UNITS_RST,
		group:    GROUP_RST,
		mcmd:     no_cmd,
		bc:       no_cmd,
		default:  '0
	};

	aes_state_s r;
	aes_state_s n;

	// ==========================================
	// Register read view
	function automatic logic [32:0] rd_val(input aes_state_s s, input logic [7:0] i);
		logic [32:0] v;
		v = '0;
		case (i)
			IDX_LAT_ACT:  v = {1'b1, s.lat_act};
			IDX_LAT_ENC:  v = {1'b1, s.lat_enc};
			IDX_ENC_MODE: v = {1'b1, 23'h00_0000, s.enc_mode};
			IDX_STEPS:    v = {1'b1, 16'h0000, s.steps};
			IDX_COIL:     v = {1'b1, 30'h0000_0000, s.coil_set};
			IDX_LOAD:     v = {1'b1, 22'h00_0000, s.s2[SY_LOAD +: LOAD_W]};
			IDX_EXT:      v = {1'b1, 30'h0000_0000, s.ext};
			IDX_DRV:      v = {1'b1, 24'h00_0000, s.still, s.s2[SY_STALL +: 7]};
			IDX_ENC_CNT:  v = {1'b1, s.enc_cnt};
			IDX_ENC_RES:  v = {1'b1, 16'h0000, s.enc_res};
			IDX_DEV_LIM:  v = {1'b1, 16'h0000, s.dev_lim};
			IDX_GROUP:    v = {1'b1, 24'h00_0000, s.group};
			IDX_IDLE_DLY: v = {1'b1, 23'h00_0000, s.idle_dly};
			IDX_SHAFT:    v = {1'b1, 31'h0000_0000, s.shaft};
			IDX_UNITS:    v = {1'b1, 31'h0000_0000, s.units};
			default:      v = '0;
		endcase
		return v;
	endfunction

	logic              qual;
	logic              act;
	logic [1:0]        ab_old;
	logic [1:0]        ab_now;
	logic signed [32:0] diff;
	logic [32:0]       mag;
	logic              over;
	logic [1:0]        ext_set;
	logic [1:0]        ext_clr;
	logic [32:0]       old_v;
	logic [31:0]       wm;
	logic [32:0]       rv;

	// ==========================================
	// Next state
	always_comb begin
		n = r;
		qual = 1'b0;
		act = 1'b0;
		ab_old = {r.s3[SY_A], r.s3[SY_B]};
		ab_now = {r.s2[SY_A], r.s2[SY_B]};
		diff = 33'(actual_position) - 33'($signed(r.enc_cnt));
		mag = diff[32] ? 33'(-diff) : 33'(diff);
		over = 1'b0;
		ext_set = 2'b00;
		ext_clr = 2'b00;
		old_v = '0;
		wm = '0;
		rv = '0;
		// Load lanes may tear while changing; single-word use only
		n.s1 = {drv_load, drv_open_b, drv_open_a, drv_short_b, drv_short_a,
			drv_overtemp_warn, drv_overtemp, drv_stall, enc_n, enc_b, enc_a};
		n.s2 = r.s1;
		n.s3 = r.s2;
		n.dev_stop = 1'b0;
		n.mcmd_v = 1'b0;
		n.bc_v = 1'b0;

		if (^(ab_now ^ ab_old)) begin
			if (ab_old[1] ~^ ab_now[0])
				n.enc_cnt = r.enc_cnt + 32'h0000_0001;
			else
				n.enc_cnt = r.enc_cnt - 32'h0000_0001;
		end

		qual = (r.s2[SY_N] == r.enc_mode[EM_N]) && (r.enc_mode[EM_IGN] ||
			(r.s2[SY_A] == r.enc_mode[EM_A] && r.s2[SY_B] == r.enc_mode[EM_B]));
		n.idx_q = qual;
		act = qual && !r.idx_q && (r.enc_mode[EM_EVERY] || r.once_armed);
		if (act) begin
			n.once_armed = 1'b0;
			n.lat_act = actual_position;
			n.lat_enc = r.enc_cnt;
			if (r.enc_mode[EM_CLR])
				n.enc_cnt = 32'h0000_0000;
		end

		if (step_pulse)
			n.still_cnt = '0;
		else if (r.still_cnt != SC_W'(STANDSTILL_CYCLES))
			n.still_cnt = r.still_cnt + SC_W'(1);
		n.still = (n.still_cnt == SC_W'(STANDSTILL_CYCLES));

		// idle delay in 10 ms units
		if (step_pulse) begin
			n.tick = '0;
			n.idle_units = 9'h000;
		end else if (r.tick == TK_W'(IDLE_UNIT_CYCLES - 1)) begin
			n.tick = '0;
			if (r.idle_units != 9'h1ff)
				n.idle_units = r.idle_units + 9'h001;
		end else begin
			n.tick = r.tick + TK_W'(1);
		end
		n.idle = !step_pulse && (n.idle_units >= r.idle_dly);
		n.coil = (n.idle && standby_current_zero) ? r.coil_set : 2'b00;

		over = (r.dev_lim != 16'h0000) && (mag > 33'(r.dev_lim));
		n.over_q = over;
		if (over && !r.over_q) begin
			n.dev_stop = 1'b1;
			ext_set[EXT_DEV] = 1'b1;
		end
		if (r.s2[SY_STALL] && !r.s3[SY_STALL])
			ext_set[EXT_STALL] = 1'b1;

		// group fan-out; a local command wins the cycle
		if (local_cmd_valid) begin
			n.mcmd_v = 1'b1;
			n.mcmd = local_cmd;
			if (r.group != 8'h00) begin
				n.bc_v = 1'b1;
				n.bc = local_cmd;
				n.bc_grp = r.group;
			end
		end else if (peer_cmd_valid && r.group != 8'h00 && peer_group == r.group) begin
			n.mcmd_v = 1'b1;
			n.mcmd = peer_cmd;
		end
		if (n.mcmd_v)
			ext_clr = 2'b11;

		// ==========================================
		// Write channel
		if (r.bvalid && s_axi_bready)
			n.bvalid = 1'b0;
		if (s_axi_awvalid && r.aw_rdy) begin
			n.aw_got = 1'b1;
			n.aw_idx = s_axi_awaddr[ADDR_W-1:2];
		end
		if (s_axi_wvalid && r.w_rdy) begin
			n.w_got = 1'b1;
			n.w_data = s_axi_wdata;
			n.w_strb = s_axi_wstrb;
		end
		if (n.aw_got && n.w_got && !n.bvalid) begin
			n.aw_got = 1'b0;
			n.w_got = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = RESP_OKAY;
			old_v = rd_val(r, n.aw_idx);
			for (int k = 0; k < 4; k++) begin
				wm[8*k +: 8] = n.w_strb[k] ? n.w_data[8*k +: 8] : old_v[8*k +: 8];
			end
			// Software write wins over same-cycle count, index clear or one-shot disarm
			case (n.aw_idx)
				IDX_ENC_MODE: begin
					// all nine bits stored as written
					n.enc_mode = wm[8:0];
					n.once_armed = wm[EM_ONCE];
				end
				IDX_STEPS:    n.steps = wm[15:0];
				IDX_COIL:     n.coil_set = wm[1:0];
				IDX_ENC_CNT:  n.enc_cnt = wm;
				IDX_ENC_RES:  n.enc_res = wm[15:0];
				IDX_DEV_LIM:  n.dev_lim = wm[15:0];
				IDX_GROUP:    n.group = wm[7:0];
				IDX_IDLE_DLY: n.idle_dly = wm[8:0];
				IDX_SHAFT:    n.shaft = wm[0];
				IDX_UNITS:    n.units = wm[0];
				default:      n.bresp = RESP_SLVERR;
			endcase
		end
		n.aw_rdy = !n.aw_got && !n.bvalid;
		n.w_rdy = !n.w_got && !n.bvalid;

		// ==========================================
		// Read channel
		if (r.rvalid && s_axi_rready)
			n.rvalid = 1'b0;
		if (s_axi_arvalid && r.ar_rdy) begin
			rv = rd_val(r, s_axi_araddr[ADDR_W-1:2]);
			n.rvalid = 1'b1;
			n.rdata = rv[31:0];
			n.rresp = rv[32] ? RESP_OKAY : RESP_SLVERR;
			if (s_axi_araddr[ADDR_W-1:2] == IDX_EXT)
				ext_clr = 2'b11;
		end
		n.ar_rdy = !n.rvalid;

		// A new event beats a same-cycle clear
		n.ext = (r.ext & ~ext_clr) | ext_set;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			r <= ST_RST;
		else
			r <= n;
	end

	// ==========================================
	// Outputs
	assign s_axi_awready      = r.aw_rdy;
	assign s_axi_wready       = r.w_rdy;
	assign s_axi_bvalid       = r.bvalid;
	assign s_axi_bresp        = r.bresp;
	assign s_axi_arready      = r.ar_rdy;
	assign s_axi_rvalid       = r.rvalid;
	assign s_axi_rdata        = r.rdata;
	assign s_axi_rresp        = r.rresp;
	assign motion_cmd_valid   = r.mcmd_v;
	assign motion_cmd         = r.mcmd;
	assign bcast_cmd_valid    = r.bc_v;
	assign bcast_cmd          = r.bc;
	assign bcast_group        = r.bc_grp;
	assign deviation_stop     = r.dev_stop;
	assign coil_mode          = r.coil;
	assign idle_current       = r.idle;
	assign shaft_invert       = r.shaft;
	assign pps_units          = r.units;
	assign steps_per_rev      = r.steps;
	assign enc_counts_per_rev = r.enc_res;
endmodule // aes_axis_params
`default_nettype wire

//--- aes_axis_params_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Port-level checks for the axis parameter block
module aes_axis_params_checker #(
	parameter int STANDSTILL_CYCLES = 16,
	parameter int IDLE_UNIT_CYCLES  = 8
) (
	// Clock and reset
	input wire logic                       clk,
	input wire logic                       reset,
	// Read channel
	input wire logic                       s_axi_arvalid,
	input wire logic                       s_axi_arready,
	input wire logic [aes_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic                       s_axi_rvalid,
	input wire logic [31:0]                s_axi_rdata,
	// Commands
	input wire logic                       local_cmd_valid,
	input wire aes_pkg::aes_cmd_e          local_cmd,
	input wire logic                       peer_cmd_valid,
	input wire logic [7:0]                 peer_group,
	input wire logic                       motion_cmd_valid,
	input wire aes_pkg::aes_cmd_e          motion_cmd,
	input wire logic                       bcast_cmd_valid,
	input wire aes_pkg::aes_cmd_e          bcast_cmd,
	input wire logic [7:0]                 bcast_group,
	// Settings
	input wire logic                       deviation_stop,
	input wire logic [1:0]                 coil_mode,
	input wire logic                       standby_current_zero,
	input wire logic                       shaft_invert,
	input wire logic                       pps_units,
	input wire logic [15:0]                steps_per_rev
);
	import aes_pkg::*;
	logic [7:0] rd_idx_reg;
	// Register index of the read in flight, for width checks
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			rd_idx_reg <= 8'h00;
		else if (s_axi_arvalid && s_axi_arready)
			rd_idx_reg <= s_axi_araddr[9:2];
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// ==========================================
	// Properties
	property p_cmd_local;
		local_cmd_valid |=> motion_cmd_valid && motion_cmd == $past(local_cmd);
	endproperty
	property p_bcast_grp;
		bcast_cmd_valid |-> bcast_group != 8'h00 && motion_cmd_valid && bcast_cmd == motion_cmd;
	endproperty
	property p_peer_zero;
		peer_cmd_valid && !local_cmd_valid && peer_group == 8'h00 |=> !motion_cmd_valid;
	endproperty
	property p_no_cmd;
		!local_cmd_valid && !peer_cmd_valid |=> !motion_cmd_valid && !bcast_cmd_valid;
	endproperty
	property p_reset_vals;
		$past(reset) |-> steps_per_rev == 16'h00c8 && pps_units && !shaft_invert;
	endproperty
	property p_coil_zero;
		(!standby_current_zero) [*2] |=> coil_mode == 2'h0;
	endproperty
	property p_dev_pulse;
		deviation_stop |=> !deviation_stop;
	endproperty
	property p_load_w;
		s_axi_rvalid && rd_idx_reg == IDX_LOAD |-> s_axi_rdata[31:10] == 22'h0;
	endproperty
	property p_ext_w;
		s_axi_rvalid && rd_idx_reg == IDX_EXT |-> s_axi_rdata[31:2] == 30'h0;
	endproperty
	property p_drv_w;
		s_axi_rvalid && rd_idx_reg == IDX_DRV |-> s_axi_rdata[31:8] == 24'h0;
	endproperty
	// ==========================================
	// Assertions
	a_cmd_local: assert property (p_cmd_local)
		else $error("local command not executed");
	a_bcast_grp: assert property (p_bcast_grp)
		else $error("bad fan-out");
	a_peer_zero: assert property (p_peer_zero)
		else $error("group 0 peer command taken");
	a_no_cmd: assert property (p_no_cmd)
		else $error("command without request");
	a_reset_vals: assert property (p_reset_vals)
		else $error("bad reset settings");
	a_coil_zero: assert property (p_coil_zero)
		else $error("coil treatment with standby current");
	a_dev_pulse: assert property (p_dev_pulse)
		else $error("deviation stop too long");
	a_load_w: assert property (p_load_w)
		else $error("load too wide");
	a_ext_w: assert property (p_ext_w)
		else $error("ext flags too wide");
	a_drv_w: assert property (p_drv_w)
		else $error("driver flags too wide");
	c_fanout: cover property (local_cmd_valid ##1 bcast_cmd_valid);
	c_dev: cover property (deviation_stop);
	c_ext: cover property (s_axi_rvalid && rd_idx_reg == IDX_EXT && s_axi_rdata != 32'h0);
endmodule // aes_axis_params_checker
bind aes_axis_params aes_axis_params_checker #(
	.STANDSTILL_CYCLES(STANDSTILL_CYCLES),
	.IDLE_UNIT_CYCLES(IDLE_UNIT_CYCLES)
) i_aes_axis_params_checker (.clk, .reset, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
	.s_axi_rvalid, .s_axi_rdata, .local_cmd_valid, .local_cmd, .peer_cmd_valid, .peer_group,
	.motion_cmd_valid, .motion_cmd, .bcast_cmd_valid, .bcast_cmd, .bcast_group,
	.deviation_stop, .coil_mode, .standby_current_zero, .shaft_invert, .pps_units,
	.steps_per_rev);
`default_nettype wire

//--- aes_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Far side: quadrature encoder and driver status pins
module aes_drive_model (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       reset,
	// Bench stimulus
	input  wire logic       fwd,
	input  wire logic       back,
	input  wire logic       index_level,
	input  wire logic [6:0] faults,
	// Pins
	output logic            enc_a,
	output logic            enc_b,
	output logic            enc_n,
	output logic [6:0]      drv_flags
);
	logic [1:0] phase;
	// Gray order: one channel moves per step, A leads B forward
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			phase <= 2'h0;
		else
			phase <= phase + {1'b0, fwd} - {1'b0, back};
	end
	assign enc_a = phase[0] ^ phase[1];
	assign enc_b = phase[1];
	assign enc_n = index_level;
	assign drv_flags = faults;
endmodule // aes_drive_model
`default_nettype wire

//--- aes_pkg.sv
`default_nettype none
package aes_pkg;
	// ==========================================
	// Register indices, byte address is index * 4
	localparam logic [7:0] IDX_LAT_ACT  = 8'hc6;
	localparam logic [7:0] IDX_LAT_ENC  = 8'hc7;
	localparam logic [7:0] IDX_ENC_MODE = 8'hc9;
	localparam logic [7:0] IDX_STEPS    = 8'hca;
	localparam logic [7:0] IDX_COIL     = 8'hcc;
	localparam logic [7:0] IDX_LOAD     = 8'hce;
	localparam logic [7:0] IDX_EXT      = 8'hcf;
	localparam logic [7:0] IDX_DRV      = 8'hd0;
	localparam logic [7:0] IDX_ENC_CNT  = 8'hd1;
	localparam logic [7:0] IDX_ENC_RES  = 8'hd2;
	localparam logic [7:0] IDX_DEV_LIM  = 8'hd4;
	localparam logic [7:0] IDX_GROUP    = 8'hd5;
	localparam logic [7:0] IDX_IDLE_DLY = 8'hd6;
	localparam logic [7:0] IDX_SHAFT    = 8'hfb;
	localparam logic [7:0] IDX_UNITS    = 8'hff;
	localparam int         ADDR_W       = 10;
	// ==========================================
	// Field positions
	localparam int EM_A     = 0;
	localparam int EM_B     = 1;
	localparam int EM_N     = 2;
	localparam int EM_IGN   = 3;
	localparam int EM_EVERY = 4;
	localparam int EM_ONCE  = 5;
	localparam int EM_CLR   = 8;
	localparam int EXT_STALL = 0;
	localparam int EXT_DEV   = 1;
	// Synchroniser lanes; driver flag bits 0..6 follow lanes 3..9
	localparam int SY_A    = 0;
	localparam int SY_B    = 1;
	localparam int SY_N    = 2;
	localparam int SY_STALL = 3;
	localparam int SY_LOAD = 10;
	localparam int LOAD_W  = 10;
	localparam int SYN_W   = 20;
	// ==========================================
	// Reset values
	localparam logic [15:0] STEPS_RST    = 16'h00c8;
	localparam logic [8:0]  IDLE_DLY_RST = 9'h0c8;
	localparam logic        UNITS_RST    = 1'h1;
	localparam logic [7:0]  GROUP_RST    = 8'h00;
	// ==========================================
	// Timing
	localparam int CLK_HZ            = 50_000_000;
	localparam int STANDSTILL_CYCLES = 2**20;
	localparam int IDLE_UNIT_MS      = 10;
	localparam int IDLE_UNIT_CYCLES  = CLK_HZ / 1000 * IDLE_UNIT_MS;
	// ==========================================
	// Bus answers and commands
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		no_cmd               = 3'h0,
		rotate_left_cmd      = 3'h1,
		rotate_right_cmd     = 3'h2,
		motor_halt_cmd       = 3'h3,
		move_to_position_cmd = 3'h4,
		reference_search_cmd = 3'h5
	} aes_cmd_e;
endpackage
`default_nettype wire

//--- test_axis_encoder_status_params.sv
`timescale 1ns/1ps
`default_nettype none
module test_axis_encoder_status_params;
	import aes_pkg::*;
	logic clk, reset, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
	logic rvalid, rready, fwd, back, nline, step, standby, lcv, pcv, mcv, bcv, dstop, idle;
	logic ea, eb, en, shinv, pps;
	logic [9:0] awaddr, araddr, load;
	logic [31:0] wdata, rdata, d, p1, p2;
	logic [1:0] bresp, rresp, coil;
	logic [6:0] faults, pins;
	logic [7:0] pgrp, bgrp, g;
	logic [15:0] spr, cpr;
	logic signed [31:0] act;
	aes_cmd_e lcmd, pcmd, mcmd, bcmd;
	int seed = 32'h6f55a1e0;
	int fail_count, n_compared, dev_cnt;
	logic [65:0] q[$];
	logic [65:0] e;
	logic [31:0] dv[10];
	logic [7:0] ti[10] = '{IDX_ENC_MODE, IDX_STEPS, IDX_COIL, IDX_ENC_CNT, IDX_ENC_RES,
		IDX_DEV_LIM, IDX_GROUP, IDX_IDLE_DLY, IDX_SHAFT, IDX_UNITS};
	logic [31:0] tm[10] = '{32'h0000_01ff, 32'h0000_ffff, 32'h0000_0003, 32'hffff_ffff,
		32'h0000_ffff, 32'h0000_ffff, 32'h0000_00ff, 32'h0000_01ff, 32'h0000_0001, 32'h0000_0001};
	aes_axis_params #(.STANDSTILL_CYCLES(16), .IDLE_UNIT_CYCLES(8)) i_aes_axis_params (
		.clk(clk), .reset(reset), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .enc_a(ea), .enc_b(eb), .enc_n(en),
		.drv_stall(pins[0]), .drv_overtemp(pins[1]), .drv_overtemp_warn(pins[2]),
		.drv_short_a(pins[3]), .drv_short_b(pins[4]), .drv_open_a(pins[5]),
		.drv_open_b(pins[6]), .drv_load(load), .actual_position(act), .step_pulse(step),
		.standby_current_zero(standby), .local_cmd_valid(lcv), .local_cmd(lcmd),
		.peer_cmd_valid(pcv), .peer_cmd(pcmd), .peer_group(pgrp), .motion_cmd_valid(mcv),
		.motion_cmd(mcmd), .bcast_cmd_valid(bcv), .bcast_cmd(bcmd), .bcast_group(bgrp),
		.deviation_stop(dstop), .coil_mode(coil), .idle_current(idle), .shaft_invert(shinv),
		.pps_units(pps), .steps_per_rev(spr), .enc_counts_per_rev(cpr));
	aes_drive_model i_aes_drive_model (.clk(clk), .reset(reset), .fwd(fwd), .back(back),
		.index_level(nline), .faults(faults), .enc_a(ea), .enc_b(eb), .enc_n(en),
		.drv_flags(pins));
	// ==========================================
	// Tasks
	task automatic chk(input logic ok, input string m);
		n_compared++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	task test_done;
		if (fail_count == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic wr(input logic [7:0] i, input logic [31:0] v, input logic [1:0] r = RESP_OKAY);
		@(posedge clk);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		awaddr <= {i, 2'b00};
		wdata <= v;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		chk(bresp === r, "write response");
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] i, input logic [31:0] x,
		input logic [31:0] m = 32'hffff_ffff, input logic [1:0] r = RESP_OKAY);
		@(posedge clk);
		arvalid <= 1'b1;
		araddr <= {i, 2'b00};
		rready <= 1'b1;
		q.push_back({r, x, m});
		do begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
	endtask
	task automatic qstep(input logic dir);
		@(posedge clk);
		fwd <= dir;
		back <= !dir;
		@(posedge clk);
		fwd <= 1'b0;
		back <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task automatic ipulse(input logic [31:0] p);
		@(posedge clk);
		act <= p;
		nline <= 1'b1;
		repeat (4) @(posedge clk);
		nline <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	task automatic pstep;
		@(posedge clk);
		step <= 1'b1;
		@(posedge clk);
		step <= 1'b0;
	endtask
	task automatic cmd(input logic loc, input aes_cmd_e c, input logic [7:0] pg,
		input logic xm, input logic xb, input logic [7:0] xg);
		@(posedge clk);
		lcv <= loc;
		pcv <= !loc;
		lcmd <= c;
		pcmd <= c;
		pgrp <= pg;
		@(posedge clk);
		lcv <= 1'b0;
		pcv <= 1'b0;
		#1;
		chk(mcv === xm && (!xm || mcmd === c) && bcv === xb && (!xb || (bcmd === c
			&& bgrp === xg)), "command");
	endtask
	// ==========================================
	// Result monitor
	always @(posedge clk) begin
		if (rvalid === 1'b1 && rready === 1'b1) begin
			e = q.pop_front();
			chk((rdata & e[31:0]) === e[63:32] && rresp === e[65:64], "read data");
		end
		if (dstop === 1'b1)
			dev_cnt++;
	end
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		#200_000;
		fail_count++;
		test_done();
	end
	// ==========================================
	// Main sequence
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, fwd, back, nline, step, standby} = '0;
		{lcv, pcv, awaddr, araddr, wdata, faults, load, pgrp, act} = '0;
		lcmd = no_cmd;
		pcmd = no_cmd;
		reset = 1'b1;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		rd(IDX_STEPS, 32'h0000_00c8);
		rd(IDX_IDLE_DLY, 32'h0000_00c8);
		rd(IDX_UNITS, 32'h0000_0001);
		rd(IDX_GROUP, 32'h0000_0000);
		rd(IDX_EXT, 32'h0000_0000);
		for (int i = 0; i < 10; i++) begin
			dv[i] = $random(seed);
			wr(ti[i], dv[i]);
			rd(ti[i], dv[i] & tm[i]);
		end
		#1;
		chk(spr === dv[1][15:0] && cpr === dv[4][15:0] && shinv === dv[8][0], "out");
		chk(pps === dv[9][0], "units");
		wr(8'hc8, dv[0], RESP_SLVERR);
		rd(8'hc8, 32'h0000_0000, 32'hffff_ffff, RESP_SLVERR);
		wr(IDX_LOAD, dv[0], RESP_SLVERR);
		wr(IDX_DEV_LIM, 32'h0000_0000);
		wr(IDX_ENC_CNT, 32'h0000_0000);
		wr(IDX_GROUP, 32'h0000_0000);
		wr(IDX_ENC_MODE, 32'h0000_0000);
		rd(IDX_EXT, 32'h0000_0000, 32'h0000_0000);
		faults <= 7'h01;
		repeat (6) @(posedge clk);
		rd(IDX_EXT, 32'h0000_0001);
		rd(IDX_EXT, 32'h0000_0000);
		d = $random(seed);
		faults <= d[6:0] | 7'h01;
		load <= d[17:8];
		repeat (6) @(posedge clk);
		pstep();
		rd(IDX_DRV, {25'h0, d[6:0] | 7'h01});
		rd(IDX_LOAD, {22'h0, d[17:8]});
		repeat (30) @(posedge clk);
		rd(IDX_DRV, {24'h0, 1'b1, d[6:0] | 7'h01});
		dev_cnt = 0;
		act <= 32'h0000_03e8;
		repeat (6) @(posedge clk);
		chk(dev_cnt === 0, "deviation with zero limit");
		wr(IDX_DEV_LIM, 32'h0000_0005);
		repeat (4) @(posedge clk);
		chk(dev_cnt === 1, "deviation stop");
		rd(IDX_EXT, 32'h0000_0002);
		wr(IDX_DEV_LIM, 32'h0000_0000);
		wr(IDX_DEV_LIM, 32'h0000_0005);
		repeat (4) @(posedge clk);
		cmd(1'b1, motor_halt_cmd, 8'h00, 1'b1, 1'b0, 8'h00);
		rd(IDX_EXT, 32'h0000_0000);
		wr(IDX_DEV_LIM, 32'h0000_0000);
		p1 = $random(seed);
		p2 = $random(seed);
		wr(IDX_ENC_MODE, 32'h0000_001c);
		repeat (3) qstep(1'b1);
		ipulse(p1);
		rd(IDX_LAT_ACT, p1);
		rd(IDX_LAT_ENC, 32'h0000_0003);
		rd(IDX_ENC_CNT, 32'h0000_0003);
		wr(IDX_ENC_MODE, 32'h0000_0117);
		ipulse(p2);
		rd(IDX_LAT_ACT, p1);
		qstep(1'b0);
		ipulse(p2);
		rd(IDX_LAT_ACT, p2);
		rd(IDX_LAT_ENC, 32'h0000_0002);
		rd(IDX_ENC_CNT, 32'h0000_0000);
		wr(IDX_ENC_MODE, 32'h0000_002c);
		ipulse(p1);
		rd(IDX_LAT_ACT, p1);
		ipulse(p2);
		rd(IDX_LAT_ACT, p1);
		g = 8'($random(seed)) | 8'h01;
		wr(IDX_GROUP, {24'h0, g});
		for (int c = 1; c < 6; c++)
			cmd(1'b1, aes_cmd_e'(c), 8'h00, 1'b1, 1'b1, g);
		cmd(1'b0, motor_halt_cmd, g, 1'b1, 1'b0, g);
		cmd(1'b0, motor_halt_cmd, g ^ 8'h80, 1'b0, 1'b0, g);
		wr(IDX_GROUP, 32'h0000_0000);
		cmd(1'b1, rotate_left_cmd, 8'h00, 1'b1, 1'b0, 8'h00);
		cmd(1'b0, rotate_left_cmd, 8'h00, 1'b0, 1'b0, 8'h00);
		standby <= 1'b1;
		wr(IDX_IDLE_DLY, 32'h0000_0003);
		for (int c = 0; c < 4; c++) begin
			wr(IDX_COIL, 32'(c));
			pstep();
			repeat (10) @(posedge clk);
			chk(idle === 1'b0 && coil === 2'h0, "early idle");
			repeat (30) @(posedge clk);
			chk(idle === 1'b1 && coil === 2'(c), "idle coil");
		end
		test_done();
	end
endmodule // test_axis_encoder_status_params
`default_nettype wire
